// ==== hw/led_pin_pkg.sv ====
/*
  Constants shared by the indicator and reset pin logic.
  Assumes a 125 MHz system clock.
*/
package led_pin_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RESET_MIN_US = 10;
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * CLK_MHZ;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int INIT_SEQ_CYCLES = 16;
  localparam logic [1:0] PIN0_MODE_RESET = 2'h0;
  localparam logic [1:0] PIN1_MODE_RESET = 2'h0;
  localparam logic [1:0] GPIO_OUT_RESET = 2'h0;

  typedef enum logic [1:0] {
    PIN1_TRISTATE = 2'b00,
    PIN1_SPEED = 2'b01,
    PIN1_GPIO = 2'b10,
    PIN1_SIGDET = 2'b11
  } pin1_mode_t;
endpackage

// ==== hw/phy_led_reset_pin_logic.sv ====
/*
  Reset pin qualification and the two indicator pins of a 10/100 PHY.
  Assumes a 125 MHz system clock; link, speed and activity come from the PHY core.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_led_reset_pin_logic #(
  parameter int RESET_MIN_CYCLES = led_pin_pkg::RESET_MIN_CYCLES,
  parameter int BLINK_HALF_CYCLES = led_pin_pkg::BLINK_HALF_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_pin_n,
  input wire logic i_link_up,
  input wire logic i_speed_100,
  input wire logic i_activity_indication,
  input wire logic i_fiber_mode,
  input wire logic i_pin0_mode_wr,
  input wire logic i_pin0_mode_act,
  input wire logic i_pin1_mode_wr,
  input wire logic [1:0] i_pin1_mode,
  input wire logic i_gpio_out_wr,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  input wire logic i_speed_indicator_pin_in,
  output logic o_link_activity_indicator,
  output logic o_speed_indicator_pin_out,
  output logic o_speed_indicator_pin_oe,
  output logic o_general_purpose_pin_one_in,
  output logic o_signal_detect,
  output logic o_core_reset,
  output logic o_reset_busy,
  output logic o_pin0_act_mode,
  output logic [1:0] o_pin1_mode
);
  // ==========================================================
  // Reset pin qualification
  logic reset_pin_n_level;
  logic pin1_level;
  logic [31:0] low_count;
  logic [7:0] seq_count;
  logic pin_reset_hit;

  // Pin idles high through its pull-up, so the synchroniser resets high
  pin_sync3 #(.RESET_VALUE(1'b1)) u_sync_reset (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_reset_pin_n),
    .o_level(reset_pin_n_level)
  );

  // Second indicator pad level; read back as GPIO input and signal detect
  pin_sync3 #(.RESET_VALUE(1'b0)) u_sync_pin1 (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_speed_indicator_pin_in),
    .o_level(pin1_level)
  );

  // Count low time; a pulse shorter than the minimum is ignored
  // Count saturates so a long hold cannot wrap and end the reset early
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      low_count <= 32'h0;
    end else if (reset_pin_n_level) begin
      low_count <= 32'h0;
    end else if (low_count < 32'(RESET_MIN_CYCLES)) begin
      low_count <= low_count + 32'h1;
    end
  end

  assign pin_reset_hit = !reset_pin_n_level && (low_count >= 32'(RESET_MIN_CYCLES - 1));

  // Full reset sequence: held while the pin is low, then a fixed tail
  // Sequence count is loaded at reset so busy stands for the tail length
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      seq_count <= 8'(led_pin_pkg::INIT_SEQ_CYCLES);
    end else if (pin_reset_hit) begin
      seq_count <= 8'(led_pin_pkg::INIT_SEQ_CYCLES);
    end else if (seq_count != 8'h0) begin
      seq_count <= seq_count - 8'h1;
    end
  end

  // Core reset covers the qualified low time plus the busy tail
  assign o_reset_busy = (seq_count != 8'h0);
  assign o_core_reset = pin_reset_hit || o_reset_busy;

  // ==========================================================
  // Function selection
  logic pin0_act;
  logic [1:0] pin1_mode;
  logic gpio_out;
  // Writes take effect on the next edge; pin drivers follow one edge later

  // Link-only or link-plus-activity choice for the first indicator
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin0_act <= led_pin_pkg::PIN0_MODE_RESET[0];
    end else if (o_core_reset) begin
      pin0_act <= led_pin_pkg::PIN0_MODE_RESET[0];
    end else if (i_pin0_mode_wr) begin
      pin0_act <= i_pin0_mode_act;
    end
  end

  // Second indicator function; writes are refused while core reset is high
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin1_mode <= led_pin_pkg::PIN1_MODE_RESET;
    end else if (o_core_reset) begin
      pin1_mode <= led_pin_pkg::PIN1_MODE_RESET;
    end else if (i_pin1_mode_wr) begin
      pin1_mode <= i_pin1_mode;
    end
  end

  // GPIO output value, only seen on the pad in GPIO function
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gpio_out <= led_pin_pkg::GPIO_OUT_RESET[0];
    end else if (o_core_reset) begin
      gpio_out <= led_pin_pkg::GPIO_OUT_RESET[0];
    end else if (i_gpio_out_wr) begin
      gpio_out <= i_gpio_out;
    end
  end

  assign o_pin0_act_mode = pin0_act;
  assign o_pin1_mode = pin1_mode;

  // ==========================================================
  // Activity blink
  logic [31:0] blink_count;
  logic blink_phase;
  logic act_pending;

  // Half-period counter; the LED is off in the odd half of each period
  // Activity during a running on half is kept so short bursts still blink; activity in the off half is dropped
  // Link loss or core reset stops blinking at once
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b0;
      act_pending <= 1'b0;
    end else if (o_core_reset || !i_link_up) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b0;
      act_pending <= 1'b0;
    end else if (blink_count != 32'h0) begin
      blink_count <= blink_count - 32'h1;
      act_pending <= act_pending || i_activity_indication;
    end else if (blink_phase || act_pending || i_activity_indication) begin
      blink_phase <= !blink_phase;
      blink_count <= 32'(BLINK_HALF_CYCLES - 1);
      act_pending <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drivers
  // Fiber mode or the detect function turns the second pin into an input
  logic fiber_sd;
  assign fiber_sd = i_fiber_mode || (pin1_mode == led_pin_pkg::PIN1_SIGDET);

  // First indicator, registered so the pad never glitches
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_link_activity_indicator <= 1'b0;
    end else if (o_core_reset) begin
      o_link_activity_indicator <= 1'b0;
    end else if (pin0_act) begin
      o_link_activity_indicator <= i_link_up && !blink_phase;
    end else begin
      o_link_activity_indicator <= i_link_up;
    end
  end

  // Second indicator pad driver; output enable high while driving
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_speed_indicator_pin_out <= 1'b0;
      o_speed_indicator_pin_oe <= 1'b0;
    end else if (o_core_reset || fiber_sd) begin
      o_speed_indicator_pin_out <= 1'b0;
      o_speed_indicator_pin_oe <= 1'b0;
    end else begin
      case (pin1_mode)
        led_pin_pkg::PIN1_SPEED: begin
          o_speed_indicator_pin_out <= i_link_up && i_speed_100;
          o_speed_indicator_pin_oe <= 1'b1;
        end
        led_pin_pkg::PIN1_GPIO: begin
          o_speed_indicator_pin_out <= gpio_out;
          o_speed_indicator_pin_oe <= i_gpio_oe;
        end
        default: begin
          o_speed_indicator_pin_out <= 1'b0;
          o_speed_indicator_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // Pad readback through the synchroniser
  assign o_general_purpose_pin_one_in = pin1_level;
  assign o_signal_detect = fiber_sd && pin1_level;
endmodule
`default_nettype wire

// ==== hw/pin_sync3.sv ====
/*
  Three-stage synchroniser with agreement filter for one pin level.
  Assumes the input is asynchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1 <= RESET_VALUE;
      s2 <= RESET_VALUE;
      s3 <= RESET_VALUE;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_level <= RESET_VALUE;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end
endmodule
`default_nettype wire

// ==== sim/led_optics_model.sv ====
/*
  Board side of the second indicator pin: LED load and optical module.
  Assumes the optical module drives the pad whenever the device does not.
*/
`timescale 1ns/1ps
`default_nettype none
module led_optics_model (
  input wire logic i_oe,
  input wire logic i_drv,
  input wire logic i_sd,
  output logic o_pad
);
  // ======
  // Pad level
  assign o_pad = i_oe ? i_drv : i_sd;
endmodule
`default_nettype wire

// ==== sim/phy_led_reset_pin_logic_props.sv ====
/*
  Concurrent checks on the pin logic ports.
  Assumes it is bound into the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_logic_props #(
  parameter int RESET_MIN_CYCLES = 8,
  parameter int BLINK_HALF_CYCLES = 4
) (
  input wire logic i_clk_sys,
  i_rst,
  i_reset_pin_n,
  i_link_up,
  i_speed_100,
  i_activity_indication,
  i_fiber_mode,
  i_pin1_mode_wr,
  o_link_activity_indicator,
  o_speed_indicator_pin_out,
  o_speed_indicator_pin_oe,
  o_core_reset,
  o_reset_busy,
  o_pin0_act_mode,
  input wire logic [1:0] i_pin1_mode,
  o_pin1_mode
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ======
  // Helpers
  wire run = !o_core_reset && !o_reset_busy;
  int lit;
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst) lit <= 0;
    else lit <= (o_link_activity_indicator && o_pin0_act_mode && i_activity_indication) ?
      lit + 1 : 0;
  sequence s_cu; (run && !i_fiber_mode)[*2]; endsequence
  // ======
  // Properties
  property p_wr; i_pin1_mode_wr && !o_core_reset |=> o_pin1_mode == $past(i_pin1_mode); endproperty
  a_wr: assert property (p_wr) else $error("mode write lost");
  property p_tri; s_cu ##0 o_pin1_mode == 2'h0 |=> !o_speed_indicator_pin_oe; endproperty
  a_tri: assert property (p_tri) else $error("tristate pin driven");
  property p_spd; s_cu ##0 o_pin1_mode == 2'h1 |=> o_speed_indicator_pin_oe &&
    o_speed_indicator_pin_out == $past(i_link_up && i_speed_100); endproperty
  a_spd: assert property (p_spd) else $error("speed led wrong");
  property p_fib; i_fiber_mode[*2] |=> !o_speed_indicator_pin_oe; endproperty
  a_fib: assert property (p_fib) else $error("detect pin driven");
  property p_led; run && !o_pin0_act_mode |=> o_link_activity_indicator == $past(i_link_up); endproperty
  a_led: assert property (p_led) else $error("link led wrong");
  property p_blink; lit <= BLINK_HALF_CYCLES + 2; endproperty
  a_blink: assert property (p_blink) else $error("no blink");
  property p_short; $rose(o_core_reset) |-> !$past(i_reset_pin_n, 4) && !$past(i_reset_pin_n, 8);
  endproperty
  a_short: assert property (p_short) else $error("short reset taken");
  property p_def; o_core_reset |=> o_pin1_mode == 2'h0 && !o_pin0_act_mode; endproperty
  a_def: assert property (p_def) else $error("mode kept in reset");
endmodule
bind phy_led_reset_pin_logic pin_logic_props #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES),
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) props_i (.*);
`default_nettype wire

// ==== sim/tb_phy_led_reset_pin_logic.sv ====
/*
  Self-checking bench for the indicator and reset pin logic.
  Assumes the package, design, pad model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_phy_led_reset_pin_logic;
  logic i_clk_sys = 0, i_rst = 1, i_reset_pin_n = 1, i_link_up = 0, i_speed_100 = 0;
  logic i_activity_indication = 0, i_fiber_mode = 0, i_pin0_mode_wr = 0, i_pin0_mode_act = 0;
  logic i_pin1_mode_wr = 0, i_gpio_out_wr = 0, i_gpio_out = 0, i_gpio_oe = 0, seen = 0;
  logic [1:0] i_pin1_mode = 2'h0, o_pin1_mode;
  logic i_speed_indicator_pin_in, o_link_activity_indicator, o_speed_indicator_pin_out;
  logic o_speed_indicator_pin_oe, o_general_purpose_pin_one_in, o_signal_detect;
  logic o_core_reset, o_reset_busy, o_pin0_act_mode;
  logic [15:0] rnd = 16'h75d0;
  logic [7:0] q[$];
  int miscompares = 0, n_checks = 0, cyc = 0, lows;
  logic [7:0] exp_pins;
  logic ref_clk = 0;
  wire [7:0] obs = {o_link_activity_indicator, o_speed_indicator_pin_oe,
    o_speed_indicator_pin_oe & o_speed_indicator_pin_out, o_signal_detect,
    o_general_purpose_pin_one_in, o_pin1_mode, o_pin0_act_mode};
  always #4 i_clk_sys = ~i_clk_sys;
  always #20 ref_clk = ~ref_clk;
  phy_led_reset_pin_logic #(.RESET_MIN_CYCLES(8), .BLINK_HALF_CYCLES(4))
    phy_led_reset_pin_logic_i (.*);
  led_optics_model led_optics_model_i (.i_oe(o_speed_indicator_pin_oe),
    .i_drv(o_speed_indicator_pin_out), .i_sd(1'b1), .o_pad(i_speed_indicator_pin_in));
  function automatic logic [15:0] xs(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    return s ^ (s << 8);
  endfunction
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ======
  // Mode step: write modes, settle, note expected pins
  task automatic step(input logic [1:0] m, input logic a, f);
    logic fe, eoe, eout;
    @(posedge i_clk_sys);
    rnd = xs(rnd);
    {i_link_up, i_speed_100, i_gpio_oe, i_gpio_out} <= rnd[3:0];
    {i_gpio_out_wr, i_pin1_mode_wr, i_pin0_mode_wr} <= 3'h7;
    {i_pin1_mode, i_pin0_mode_act, i_fiber_mode} <= {m, a, f};
    @(posedge i_clk_sys);
    {i_gpio_out_wr, i_pin1_mode_wr, i_pin0_mode_wr} <= 3'h0;
    fe = f | (m == 2'h3);
    eoe = !fe & ((m == 2'h1) | ((m == 2'h2) & rnd[1]));
    eout = (m == 2'h1) ? rnd[3] & rnd[2] : rnd[0];
    repeat (6) @(posedge i_clk_sys);
    q.push_back({rnd[3], eoe, eoe & eout, fe, eoe ? eout : 1'b1, m, a});
    seen <= 1;
    @(posedge i_clk_sys);
    seen <= 0;
  endtask
  always @(negedge i_clk_sys) begin
    cyc++;
    if (cyc > 4000) begin
      miscompares++;
      summarize();
    end else if (seen) begin
      exp_pins = q.pop_front();
      `CHK("pins", exp_pins, obs)
    end
  end
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 0;
    @(negedge i_clk_sys);
    `CHK("busy", 1'b1, o_reset_busy)
    repeat (20) @(posedge i_clk_sys);
    `CHK("busy", 1'b0, o_reset_busy)
    for (int i = 0; i < 32; i++) step(i[1:0], i[2], i[3]);
    for (int a = 0; a < 2; a++) begin
      step(2'h1, a[0], 1'b0);
      {i_link_up, i_activity_indication} <= 2'h3;
      repeat (4) @(posedge i_clk_sys);
      lows = 0;
      repeat (20) @(negedge i_clk_sys) lows += !o_link_activity_indicator;
      @(posedge i_clk_sys) i_activity_indication <= 0;
      `CHK("blink", a != 0, lows > 0)
    end
    for (int w = 3; w < 30; w += 20) begin
      step(2'h2, 1'b1, 1'b0);
      i_reset_pin_n <= 0;
      lows = 0;
      repeat (w) @(negedge i_clk_sys) lows += o_core_reset;
      @(posedge i_clk_sys) i_reset_pin_n <= 1;
      repeat (60) @(negedge i_clk_sys) lows += o_core_reset;
      `CHK("core reset", w > 8, lows > 0)
      `CHK("modes", (w > 8) ? 3'h0 : 3'h5, {o_pin1_mode, o_pin0_act_mode})
    end
    summarize();
  end
endmodule
`default_nettype wire
